//--- shared/adcc_map.svh
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
// Register byte addresses.
`define ADCC_CTRL0_ADDR     4'h0
`define ADCC_CTRL1_ADDR     4'h4
`define ADCC_CTRL2_ADDR     4'h8
`define ADCC_RESH_ADDR      4'hc
`define ADCC_RESL_ADDR      4'h0
// Control register 0 fields.
`define ADCC_C0_START       7
`define ADCC_C0_BUSY        6
`define ADCC_C0_POWER       5
`define ADCC_C0_CH_LSB      0
// Control register 1 fields.
`define ADCC_C1_SRC_LSB     4
`define ADCC_C1_DIV_LSB     0
// Control register 2 fields.
`define ADCC_C2_FMT         0
`define ADCC_C2_REF_LSB     1
`define ADCC_C2_AMPSRC      3
`define ADCC_C2_GAIN_LSB    4
`define ADCC_C2_IRQEN       6
`define ADCC_C2_IRQREQ      7
// Timing in converter clock periods.
`define ADCC_SAMPLE_CLKS    5'h04
`define ADCC_CONV_CLKS      5'h0c
`define ADCC_TOTAL_CLKS     5'h10
`define ADCC_FULL_SCALE     12'hfff
`endif

//--- shared/adcc_pkg.sv
package adcc_pkg;
  typedef enum logic [1:0] {
    ADCC_IDLE   = 2'b00,
    ADCC_SAMPLE = 2'b01,
    ADCC_CONV   = 2'b10
  } adcc_state_type;
  typedef logic [11:0] adcc_code_type;
endpackage : adcc_pkg

//--- verilog/adcc_control.sv
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "adcc_map.svh"

module adcc_control (
  // System
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [3:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       wb_err_o,
  // Analog front end
  input  wire adcc_pkg::adcc_code_type comparator_code,
  input  wire logic                  global_irq_enable,
  output logic                       conv_power_enable,
  output logic                       conv_clock,
  output logic                       sample_hold,
  output logic [7:0]                 ext_channel_onehot,
  output logic [6:0]                 internal_source_onehot,
  output logic [1:0]                 reference_sel,
  output logic                       amp_input_sel,
  output logic [1:0]                 amp_gain_sel,
  output logic                       conv_irq
);
  import adcc_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic           start_bit;
  logic [2:0]     conv_clock_div_sel;
  logic [3:0]     input_source_sel;
  logic [3:0]     ext_channel_sel;
  logic           result_format_sel;
  logic [1:0]     ref_field;
  logic           amp_src;
  logic [1:0]     amp_gain;
  logic           conv_irq_enable;
  logic           conv_irq_request;
  logic           power;
  // Result bytes survive a power drop; only reset clears them.
  logic [7:0]     result_high_reg;
  logic [7:0]     result_low_reg;
  adcc_state_type state;
  logic [6:0]     div_count;
  logic [4:0]     clk_count;
  logic           armed;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // A request is taken once; the registered answer blocks a second take
  // of the same strobe in the acknowledge cycle.
  wire        access    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire        hit0      = wb_adr_i == `ADCC_CTRL0_ADDR;
  wire        hit1      = wb_adr_i == `ADCC_CTRL1_ADDR;
  wire        hit2      = wb_adr_i == `ADCC_CTRL2_ADDR;
  wire        hit3      = wb_adr_i == `ADCC_RESH_ADDR;
  wire        mapped    = hit0 | hit1 | hit2 | hit3;
  wire        wr_lane0  = access & wb_we_i & wb_sel_i[0];
  wire        wr0       = wr_lane0 & hit0;
  wire        wr1       = wr_lane0 & hit1;
  wire        wr2       = wr_lane0 & hit2;
  // Busy is read from the state itself, so it rises the cycle after the
  // final start write and falls in the cycle the results are written.
  wire        busy      = state != ADCC_IDLE;

  // Results share one word: high byte in [15:8], low byte in [7:0].
  wire [31:0] rd0 = {24'h0, start_bit, busy, power, 1'b0, ext_channel_sel};
  wire [31:0] rd1 = {24'h0, input_source_sel, 1'b0, conv_clock_div_sel};
  wire [31:0] rd2 = {24'h0, conv_irq_request, conv_irq_enable, amp_gain, amp_src,
                     ref_field, result_format_sel};
  wire [31:0] rd3 = {16'h0, result_high_reg, result_low_reg};
  wire [31:0] next_rdata = hit0 ? rd0 : hit1 ? rd1 : hit2 ? rd2 : rd3;

  // ---------------------------------------------------------------
  // Converter clock divider
  // ---------------------------------------------------------------
  // Divisor is 2**sel; the tick marks one converter clock period.
  // At divide by one the tick fires every cycle and the clock output
  // simply stays high, since a flop on the system clock cannot toggle
  // faster than half that rate.
  wire [6:0] div_last = 7'(({7'h0, 1'b1} << conv_clock_div_sel) - 8'h01);
  wire       tick     = power & (div_count == div_last);

  // ---------------------------------------------------------------
  // Start detection and sequencer
  // ---------------------------------------------------------------
  wire next_start = wr0 ? wb_dat_i[`ADCC_C0_START] : start_bit;
  // Rising edge arms, falling edge launches; a level alone does nothing.
  wire launch     = armed & start_bit & ~next_start & power;
  wire phase_end  = tick & (clk_count == `ADCC_TOTAL_CLKS - 5'h01);
  wire finish     = busy & phase_end;

  // Right-justified puts the code in the low 12 bits; left-justified
  // puts it in the high 12 bits with the low nibble zero.
  wire [15:0] placed = result_format_sel ? {4'h0, comparator_code}
                                         : {comparator_code, 4'h0};

  // ---------------------------------------------------------------
  // Input and source decode
  // ---------------------------------------------------------------
  // Codes 0100 and 11xx connect nothing; code 0000 is the external path.
  function automatic logic [6:0] source_decode(input logic [3:0] code);
    logic [6:0] sel;
    sel = 7'h00;
    unique casez (code)
      4'b0001: sel = 7'h01;
      4'b0010: sel = 7'h02;
      4'b0011: sel = 7'h04;
      4'b0101: sel = 7'h08;
      4'b0110: sel = 7'h10;
      4'b0111: sel = 7'h20;
      4'b10??: sel = 7'h40;
      default: sel = 7'h00;
    endcase
    return sel;
  endfunction : source_decode

  // Channel codes with the top bit set leave the converter input floating;
  // any internal source code opens the external switch.
  wire       ext_mode  = input_source_sel == 4'h0;
  wire [7:0] next_ext  = (ext_mode & ~ext_channel_sel[3] & power)
                         ? 8'(8'h01 << ext_channel_sel[2:0]) : 8'h00;
  wire [6:0] next_int  = power ? source_decode(input_source_sel) : 7'h00;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      start_bit          <= 1'b0;
      power              <= 1'b0;
      ext_channel_sel    <= 4'h0;
      conv_clock_div_sel <= 3'h0;
      input_source_sel   <= 4'h0;
      result_format_sel  <= 1'b0;
      ref_field          <= 2'h0;
      amp_src            <= 1'b0;
      amp_gain           <= 2'h0;
      conv_irq_enable    <= 1'b0;
    end else begin
      start_bit <= next_start;
      if (wr0) begin
        power           <= wb_dat_i[`ADCC_C0_POWER];
        ext_channel_sel <= wb_dat_i[`ADCC_C0_CH_LSB +: 4];
      end
      if (wr1) begin
        conv_clock_div_sel <= wb_dat_i[`ADCC_C1_DIV_LSB +: 3];
        input_source_sel   <= wb_dat_i[`ADCC_C1_SRC_LSB +: 4];
      end
      if (wr2) begin
        result_format_sel <= wb_dat_i[`ADCC_C2_FMT];
        ref_field         <= wb_dat_i[`ADCC_C2_REF_LSB +: 2];
        amp_src           <= wb_dat_i[`ADCC_C2_AMPSRC];
        amp_gain          <= wb_dat_i[`ADCC_C2_GAIN_LSB +: 2];
        conv_irq_enable   <= wb_dat_i[`ADCC_C2_IRQEN];
      end
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  // A clear written in the completion cycle is lost; software reads again.
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_irq_request <= 1'b0;
    end else if (finish) begin
      conv_irq_request <= 1'b1;
    end else if (wr2) begin
      conv_irq_request <= wb_dat_i[`ADCC_C2_IRQREQ];
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // One counter spans both phases: four ticks end sampling and sixteen end
  // the conversion, so the phase boundary needs no second counter.
  // Dropping power aborts a conversion and leaves results and request
  // untouched, so software never reads a half-finished code.
  always_ff @(posedge clk) begin
    if (rst) begin
      state     <= ADCC_IDLE;
      div_count <= 7'h00;
      clk_count <= 5'h00;
      armed     <= 1'b0;
    end else begin
      div_count <= (tick | ~power | launch) ? 7'h00 : div_count + 7'h01;
      armed     <= next_start ? (armed | ~start_bit) : 1'b0;
      unique case (state)
        ADCC_IDLE: begin
          clk_count <= 5'h00;
          if (launch) begin
            state <= ADCC_SAMPLE;
          end
        end
        ADCC_SAMPLE: begin
          if (~power) begin
            state <= ADCC_IDLE;
          end else if (tick) begin
            clk_count <= clk_count + 5'h01;
            if (clk_count == `ADCC_SAMPLE_CLKS - 5'h01) begin
              state <= ADCC_CONV;
            end
          end
        end
        ADCC_CONV: begin
          if (~power | finish) begin
            state <= ADCC_IDLE;
          end else if (tick) begin
            clk_count <= clk_count + 5'h01;
          end
        end
        default: state <= ADCC_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Result registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      result_high_reg <= 8'h00;
      result_low_reg  <= 8'h00;
    end else if (finish & power) begin
      result_high_reg <= placed[15:8];
      result_low_reg  <= placed[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Read data is forced to zero outside the acknowledge cycle, so a stale
  // word on the bus can never be taken for an answer.
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o               <= 1'b0;
      wb_err_o               <= 1'b0;
      wb_dat_o               <= 32'h0;
    end else begin
      wb_ack_o               <= access & mapped;
      wb_err_o               <= access & ~mapped;
      wb_dat_o               <= (access & mapped & ~wb_we_i) ? next_rdata : 32'h0;
    end
  end

  // The interrupt line is a registered product of the request and both
  // enables, so it follows a clear or an enable change one cycle late.
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_power_enable      <= 1'b0;
      conv_clock             <= 1'b0;
      sample_hold            <= 1'b0;
      ext_channel_onehot     <= 8'h00;
      internal_source_onehot <= 7'h00;
      reference_sel          <= 2'h0;
      amp_input_sel          <= 1'b0;
      amp_gain_sel           <= 2'h0;
      conv_irq               <= 1'b0;
    end else begin
      conv_power_enable      <= power;
      conv_clock             <= power & (div_count <= (div_last >> 1));
      sample_hold            <= state == ADCC_SAMPLE;
      ext_channel_onehot     <= next_ext;
      internal_source_onehot <= next_int;
      reference_sel          <= ref_field;
      amp_input_sel          <= amp_src;
      amp_gain_sel           <= amp_gain;
      conv_irq <= conv_irq_request & conv_irq_enable & global_irq_enable;
    end
  end
endmodule : adcc_control

//--- verification/adcc_control_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the conversion control.
// ----------------------------------------
module adcc_control_checker (
  // System
  input wire logic        clk,
  input wire logic        rst,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic [31:0] wb_dat_o,
  // Converter
  input wire logic        global_irq_enable,
  input wire logic        conv_power_enable,
  input wire logic        conv_clock,
  input wire logic        sample_hold,
  input wire logic [7:0]  ext_channel_onehot,
  input wire logic [6:0]  internal_source_onehot,
  input wire logic        conv_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o || wb_err_o) else $error("no bus answer");
  chk_ack_err: assert property (!(wb_ack_o && wb_err_o)) else $error("ack with err");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
  // The power bit may reach the outputs one cycle late, so two low cycles are needed.
  chk_power_off: assert property (!conv_power_enable && !$past(conv_power_enable) |->
    !conv_clock && !sample_hold && ext_channel_onehot == 8'h00) else $error("power off");
  chk_ext_onehot: assert property ($onehot0(ext_channel_onehot)) else $error("ext");
  chk_int_onehot: assert property ($onehot0(internal_source_onehot)) else $error("int");
  chk_src_excl: assert property (|internal_source_onehot |->
    ext_channel_onehot == 8'h00) else $error("both sources");
  chk_irq_global: assert property (!$past(global_irq_enable) |-> !conv_irq)
    else $error("irq without global enable");
  cover property ($rose(sample_hold));
  cover property (wb_err_o);
  cover property ($fell(conv_irq));
endmodule : adcc_control_checker

bind adcc_control adcc_control_checker adcc_control_checker_i (.clk, .rst, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .wb_err_o, .wb_dat_o, .global_irq_enable, .conv_power_enable,
  .conv_clock, .sample_hold, .ext_channel_onehot, .internal_source_onehot, .conv_irq);

//--- verification/adcc_control_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
// ----------------------------------------
// Queue-checked bench.
// ----------------------------------------
module adcc_control_test;
  import adcc_pkg::*;
  typedef struct packed {logic err; logic [31:0] exp; logic [31:0] mask;} adcc_note_type;
  logic clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, r, lfsr = 32'hb44b;
  logic wb_ack_o, wb_err_o, global_irq_enable = 1'b0, conv_power_enable, conv_clock;
  logic sample_hold, amp_input_sel, conv_irq;
  adcc_code_type comparator_code = 12'h000;
  logic [7:0] ext_channel_onehot;
  logic [6:0] internal_source_onehot;
  logic [1:0] reference_sel, amp_gain_sel;
  adcc_note_type q[$];
  adcc_note_type n;
  int error_cnt, tests_run, cyc_cnt, i, j, t0, dt, d, h0, hold_cnt;
  always #5 clk = ~clk;
  adcc_control adcc_control_i (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .comparator_code,
    .global_irq_enable, .conv_power_enable, .conv_clock, .sample_hold, .ext_channel_onehot,
    .internal_source_onehot, .reference_sel, .amp_input_sel, .amp_gain_sel, .conv_irq);
  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : next_rand
  function automatic logic [14:0] src_exp(input int s, input int c);
    logic [6:0] m;
    m = (s == 0 || s == 4 || s >= 12) ? 7'h00 : (s >= 8) ? 7'h40 :
        (s >= 5) ? 7'h01 << (s - 2) : 7'h01 << (s - 1);
    return {(s == 0 && c < 8) ? 8'h01 << c : 8'h00, m};
  endfunction : src_exp
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
                    input logic e, input logic [31:0] x, input logic [31:0] m);
    q.push_back({e, x, m});
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // A hung handshake stops the run here rather than in the driver.
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    hold_cnt <= hold_cnt + int'(sample_hold === 1'b1);
    if (cyc_cnt == 20000) begin
      error_cnt++;
      summarize();
    end
    if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
      n = q.pop_front();
      `CHK({wb_err_o, wb_dat_o & n.mask}, {n.err, n.exp})
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) wb(4'(i * 4), 1'b0, 0, 1'b0, 0, 32'hffffffff);
    wb(4'h2, 1'b1, 32'h55, 1'b1, 0, 0);
    $display("test reset done");
    for (i = 0; i < 3; i++) wb(4'h0, 1'b1, 32'(i % 2 * 8'h80), 1'b0, 0, 0);
    wb(4'h0, 1'b0, 0, 1'b0, 0, 32'h40);
    wb(4'hc, 1'b0, 0, 1'b0, 0, 32'hffff);
    $display("test unpowered start done");
    for (j = 0; j < 2; j++) begin
      r = next_rand();
      wb(4'h0, 1'b1, j ? 32'h28 : 32'h20 | r[2:0], 1'b0, 0, 0);
      for (i = 0; i < 16; i++) begin
        wb(4'h4, 1'b1, 32'(i << 4), 1'b0, 0, 0);
        repeat (2) @(posedge clk);
        `CHK({ext_channel_onehot, internal_source_onehot}, src_exp(i, j ? 8 : r[2:0]))
      end
    end
    $display("test source select done");
    for (i = 0; i < 3; i++) begin
      r = next_rand();
      d = 7 - i % 2;
      comparator_code <= r[11:0];
      global_irq_enable <= (i != 1);
      wb(4'h4, 1'b1, 32'(d), 1'b0, 0, 0);
      wb(4'h8, 1'b1, {24'h0, 2'b01, r[17:13], 1'(i % 2)}, 1'b0, 0, 0);
      for (j = 0; j < 3; j++) wb(4'h0, 1'b1, 32'(j == 1 ? 8'ha0 : 8'h20), 1'b0, 0, 0);
      t0 = cyc_cnt;
      h0 = hold_cnt;
      wb(4'h0, 1'b0, 0, 1'b0, 32'h40, 32'h40);
      do wb(4'h0, 1'b0, 0, 1'b0, 0, 0); while (rd[6] === 1'b1 && cyc_cnt - t0 < 5000);
      dt = cyc_cnt - t0;
      `CHK(dt > (16 << d) && dt <= (16 << d) + 3, 1'b1)
      `CHK(hold_cnt - h0, 4 << d)
      `CHK(conv_power_enable, 1'b1)
      `CHK({reference_sel, amp_input_sel, amp_gain_sel}, {r[14:13], r[15], r[17:16]})
      wb(4'hc, 1'b0, 0, 1'b0, i % 2 ? {20'h0, r[11:0]} : {16'h0, r[11:0], 4'h0}, 32'hffff);
      wb(4'h8, 1'b0, 0, 1'b0, 32'h80, 32'h80);
      `CHK(conv_irq, 1'(i != 1))
      wb(4'h8, 1'b1, 32'h40, 1'b0, 0, 0);
      repeat (2) @(posedge clk);
      `CHK(conv_irq, 1'b0)
      $display("test conversion %0d done", i);
    end
    wb(4'h0, 1'b1, 0, 1'b0, 0, 0);
    repeat (4) @(posedge clk);
    `CHK({conv_power_enable, conv_clock, sample_hold, ext_channel_onehot}, 11'h000)
    summarize();
  end
endmodule : adcc_control_test
